// ### cetm_bus_node.sv
// Behavioural model of the other nodes sharing the CAN wire.
`timescale 1ns/1ps
module cetm_bus_node (
   input logic ref_clk,
   input logic resetn,
   input logic canTx,
   input logic busActive,
   input logic quantumTick,
   output logic canRx
);
   logic [7:0] lfsr_q;
   logic [7:0] lfsr_d;

   // Outside a frame the others stay recessive, so only our own bit shows on the wire.
   always_comb begin
      lfsr_d = lfsr_q;
      if (!busActive) begin
         lfsr_d = 8'hFF;
      end else if (quantumTick) begin
         lfsr_d = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         lfsr_q <= 8'hFF;
      end else begin
         lfsr_q <= lfsr_d;
      end
   end

   // A dominant zero from any node wins on the wire.
   assign canRx = canTx & lfsr_q[0];
endmodule : cetm_bus_node

// ### cetm_core.sv
// Error tracking, bit timing, page select and transmit mailbox control of the CAN block.
`timescale 1ns/1ps
`include "cetm_regs.svh"

module cetm_core (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   input wire logic canRx,
   output logic canTx,
   input wire logic busActive,
   input wire logic errDetect,
   input wire logic [2:0] errCode,
   input wire logic rxErrEvent,
   input wire logic rxErrBig,
   input wire logic txErrEvent,
   input wire logic txErrBig,
   input wire logic rxGood,
   input wire logic txGood,
   input wire logic [1:0] attemptDone,
   input wire logic attemptOk,
   input wire logic attemptLost,
   input wire logic resyncReq,
   input wire logic resyncLonger,
   input wire logic [1:0] resyncPhase,
   input wire logic protoTx,
   output logic [1:0] sendPending,
   output logic [1:0] abortPending,
   output logic [1:0] mailboxEmpty,
   output logic mailboxWriteEn,
   output logic [2:0] pageNumber,
   output logic samplePoint,
   output logic quantumTick,
   output logic initAcknowledge,
   output logic errorIrq,
   output logic errorIrqFlag
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [2:0] lecQ, lecD;
   logic busOffQ, busOffD;
   logic [7:0] irqEnQ, irqEnD;
   logic errIrqFlagQ, errIrqFlagD;
   logic [8:0] tecQ, tecD;
   logic [7:0] recQ, recD;
   logic silentQ, silentD, loopQ, loopD;
   logic sampleQ, sampleD;
   logic [7:0] prescaleQ, prescaleD;
   logic [6:0] segmentsQ, segmentsD;
   logic [2:0] pageQ, pageD;
   logic initReqQ, initReqD;
   cetm_pkg::cetm_mode_e modeQ, modeD;
   logic [5:0] mbQ [2], mbD [2];
   logic [7:0] rdDataQ, rdDataD;
   logic passiveFlag, warnFlag, passivePrevQ, warnPrevQ;

   // Write decode used by the registers below except the mailboxes and the master status clear.
   function automatic logic wrHit(input logic [3:0] off);
      wrHit = regWrite && (regAddr == off);
   endfunction : wrHit

   assign passiveFlag = (tecQ > `CETM_PASSIVE_LIMIT) ||
                        ({1'b0, recQ} > `CETM_PASSIVE_LIMIT);
   assign warnFlag = (tecQ > `CETM_WARN_LIMIT) ||
                     ({1'b0, recQ} > `CETM_WARN_LIMIT);

   // ----------------------------------------------------------------
   // Error status, counters and error interrupt flag
   // ----------------------------------------------------------------
   always_comb begin
      lecD = lecQ;
      if (wrHit(`CETM_OFF_ERROR_STATUS)) begin
         lecD = regWrData[6:4];
      end
      if (rxGood || txGood) begin
         lecD = cetm_pkg::CETM_LEC_NONE;
      end
      if (errDetect && errCode != `CETM_LEC_SOFT) begin
         lecD = errCode;
      end
      irqEnD = irqEnQ;
      if (wrHit(`CETM_OFF_ERROR_IRQ_EN)) begin
         irqEnD = regWrData & 8'h97;
      end
      tecD = tecQ;
      if (modeQ == cetm_pkg::CETM_INIT && !busOffQ) begin
         tecD = 9'h000;
      end else if (txErrEvent && !busOffQ) begin
         // Saturate past 255 so the ninth bit only ever signals overflow.
         tecD = (tecQ > `CETM_BUSOFF_LIMIT) ? tecQ :
                tecQ + (txErrBig ? 9'd8 : 9'd1);
      end else if (txGood && tecQ != 9'h000) begin
         tecD = tecQ - 9'd1;
      end
      recD = recQ;
      if (rxErrEvent) begin
         if (recQ <= 8'hF7) begin
            recD = recQ + (rxErrBig ? `CETM_REC_BIG_STEP : 8'd1);
         end else begin
            recD = 8'hFF;
         end
      end else if (rxGood) begin
         if (recQ > `CETM_REC_HIGH) begin
            recD = `CETM_REC_RELOAD;
         end else if (recQ != 8'h00) begin
            recD = recQ - 8'd1;
         end
      end
      busOffD = busOffQ;
      if (tecD > `CETM_BUSOFF_LIMIT) begin
         busOffD = 1'b1;
      end
      errIrqFlagD = errIrqFlagQ;
      if (regWrite && regAddr == `CETM_OFF_MASTER_STATUS && regWrData[2]) begin
         errIrqFlagD = 1'b0;
      end
      // Sets come last so an event in the clearing cycle is kept.
      if (errDetect && errCode != `CETM_LEC_SOFT && irqEnQ[`CETM_BIT_CODE_UPDATE_IRQ_ENABLE]) begin
         errIrqFlagD = 1'b1;
      end
      if ((busOffD && !busOffQ && irqEnQ[`CETM_BIT_BUS_OFF_FLAG]) ||
          (passiveFlag && !passivePrevQ && irqEnQ[`CETM_BIT_ERROR_PASSIVE_FLAG]) ||
          (warnFlag && !warnPrevQ && irqEnQ[`CETM_BIT_ERROR_WARNING_FLAG])) begin
         errIrqFlagD = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         lecQ <= 3'h0;
         irqEnQ <= 8'h00;
         tecQ <= 9'h000;
         recQ <= 8'h00;
         busOffQ <= 1'b0;
         errIrqFlagQ <= 1'b0;
         passivePrevQ <= 1'b0;
         warnPrevQ <= 1'b0;
      end else begin
         lecQ <= lecD;
         irqEnQ <= irqEnD;
         tecQ <= tecD;
         recQ <= recD;
         busOffQ <= busOffD;
         errIrqFlagQ <= errIrqFlagD;
         passivePrevQ <= passiveFlag;
         warnPrevQ <= warnFlag;
      end
   end

   assign errorIrqFlag = errIrqFlagQ;
   assign errorIrq = irqEnQ[`CETM_BIT_ERROR_IRQ_ENABLE] && errIrqFlagQ;

   // ----------------------------------------------------------------
   // Diagnosis, timing, page and init mode
   // ----------------------------------------------------------------
   logic [5:0] qCntQ, qCntD;
   logic [4:0] tqCntQ, tqCntD;
   cetm_pkg::cetm_seg_e segQ, segD;
   logic [4:0] segLen, jump, phaseStep;

   always_comb begin
      silentD = silentQ;
      loopD = loopQ;
      if (wrHit(`CETM_OFF_DIAGNOSIS)) begin
         silentD = regWrData[1];
         loopD = regWrData[0];
      end
      prescaleD = prescaleQ;
      segmentsD = segmentsQ;
      // Timing registers only take writes in init mode so a live frame is never reshaped.
      if (wrHit(`CETM_OFF_TIMING_PRESCALE) && modeQ == cetm_pkg::CETM_INIT) begin
         prescaleD = regWrData;
      end
      if (wrHit(`CETM_OFF_TIMING_SEGMENTS) && modeQ == cetm_pkg::CETM_INIT) begin
         segmentsD = regWrData[6:0];
      end
      pageD = pageQ;
      if (wrHit(`CETM_OFF_PAGE_SELECT)) begin
         pageD = regWrData[2:0];
      end
      initReqD = initReqQ;
      if (wrHit(`CETM_OFF_MASTER_CONTROL)) begin
         initReqD = regWrData[0];
      end
      modeD = modeQ;
      case (modeQ)
         cetm_pkg::CETM_RUN: if (initReqQ) modeD = cetm_pkg::CETM_INIT_WAIT;
         cetm_pkg::CETM_INIT_WAIT: begin
            if (!initReqQ) modeD = cetm_pkg::CETM_RUN;
            else if (!busActive) modeD = cetm_pkg::CETM_INIT;
         end
         cetm_pkg::CETM_INIT: if (!initReqQ) modeD = cetm_pkg::CETM_RUN;
         default: modeD = cetm_pkg::CETM_RUN;
      endcase
      // Quantum prescaler and bit segment sequencer.
      quantumTick = (qCntQ == prescaleQ[5:0]);
      qCntD = quantumTick ? 6'h00 : qCntQ + 6'h01;
      jump = {3'b000, prescaleQ[7:6]} + 5'd1;
      segLen = (segQ == cetm_pkg::CETM_SEG_ONE) ? {1'b0, segmentsQ[3:0]} + 5'd1 :
               (segQ == cetm_pkg::CETM_SEG_TWO) ? {2'b00, segmentsQ[6:4]} + 5'd1 :
               5'd1;
      phaseStep = ({3'b000, resyncPhase} < jump) ? {3'b000, resyncPhase} : jump;
      if (resyncReq && segQ == cetm_pkg::CETM_SEG_ONE && resyncLonger) begin
         segLen = segLen + phaseStep;
      end else if (resyncReq && segQ == cetm_pkg::CETM_SEG_TWO && !resyncLonger) begin
         // Clamp at one quantum: a wrapped length would stretch the bit instead.
         segLen = (segLen > phaseStep) ? segLen - phaseStep : 5'd1;
      end
      tqCntD = tqCntQ;
      segD = segQ;
      sampleD = sampleQ;
      if (quantumTick) begin
         if (tqCntQ + 5'd1 >= segLen) begin
            tqCntD = 5'd0;
            case (segQ)
               cetm_pkg::CETM_SEG_SYNC: segD = cetm_pkg::CETM_SEG_ONE;
               cetm_pkg::CETM_SEG_ONE: begin
                  segD = cetm_pkg::CETM_SEG_TWO;
                  sampleD = canRx;
               end
               cetm_pkg::CETM_SEG_TWO: segD = cetm_pkg::CETM_SEG_SYNC;
               default: segD = cetm_pkg::CETM_SEG_SYNC;
            endcase
         end else begin
            tqCntD = tqCntQ + 5'd1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         silentQ <= 1'b0;
         loopQ <= 1'b0;
         sampleQ <= 1'b1;
         prescaleQ <= 8'h00;
         segmentsQ <= `CETM_RST_SEGMENTS;
         pageQ <= `CETM_RST_PAGE;
         initReqQ <= 1'b0;
         modeQ <= cetm_pkg::CETM_RUN;
         qCntQ <= 6'h00;
         tqCntQ <= 5'd0;
         segQ <= cetm_pkg::CETM_SEG_SYNC;
      end else begin
         silentQ <= silentD;
         loopQ <= loopD;
         sampleQ <= sampleD;
         prescaleQ <= prescaleD;
         segmentsQ <= segmentsD;
         pageQ <= pageD;
         initReqQ <= initReqD;
         modeQ <= modeD;
         qCntQ <= qCntD;
         tqCntQ <= tqCntD;
         segQ <= segD;
      end
   end

   assign samplePoint = sampleQ;
   assign pageNumber = pageQ;
   assign initAcknowledge = (modeQ == cetm_pkg::CETM_INIT);
   // Silent mode keeps the bus recessive; loop-back also keeps the node off the bus.
   assign canTx = (silentQ || loopQ) ? 1'b1 : protoTx;

   // ----------------------------------------------------------------
   // Transmit mailboxes
   // ----------------------------------------------------------------
   for (genvar m = 0; m < 2; m++) begin : g_mb
      logic wrMb, clrDone, newReq, abortSet;
      assign wrMb = regWrite && (regAddr == (m[0] ? `CETM_OFF_MAILBOX1 : `CETM_OFF_MAILBOX0));
      assign newReq = wrMb && regWrData[`CETM_BIT_SEND_REQUEST] && !mbQ[m][`CETM_BIT_SEND_REQUEST];
      assign clrDone = (wrMb && regWrData[`CETM_BIT_REQUEST_COMPLETED]) ||
                       (regWrite && regAddr == `CETM_OFF_TRANSMIT_STATUS && regWrData[m]);
      assign abortSet = wrMb && regWrData[`CETM_BIT_ABORT_REQUEST] && mbQ[m][`CETM_BIT_SEND_REQUEST];
      always_comb begin
         mbD[m] = mbQ[m];
         if (clrDone || newReq) begin
            mbD[m][5:2] = 4'h0;
         end
         if (newReq) begin
            mbD[m][`CETM_BIT_SEND_REQUEST] = 1'b1;
         end
         if (abortSet) begin
            mbD[m][`CETM_BIT_ABORT_REQUEST] = 1'b1;
         end
         if (attemptDone[m] && mbQ[m][`CETM_BIT_SEND_REQUEST]) begin
            mbD[m][`CETM_BIT_TX_ERROR_STATUS] = !attemptOk && !attemptLost;
            mbD[m][`CETM_BIT_ARBITRATION_LOST] = attemptLost;
            mbD[m][`CETM_BIT_TX_SUCCESS] = attemptOk;
            if (attemptOk || mbQ[m][`CETM_BIT_ABORT_REQUEST]) begin
               mbD[m][`CETM_BIT_REQUEST_COMPLETED] = 1'b1;
               mbD[m][1:0] = 2'b00;
            end
         end else if (mbQ[m][`CETM_BIT_ABORT_REQUEST] && !busActive) begin
            mbD[m][`CETM_BIT_REQUEST_COMPLETED] = 1'b1;
            mbD[m][1:0] = 2'b00;
         end
      end
      assign sendPending[m] = mbQ[m][`CETM_BIT_SEND_REQUEST];
      assign abortPending[m] = mbQ[m][`CETM_BIT_ABORT_REQUEST];
      assign mailboxEmpty[m] = !mbQ[m][`CETM_BIT_SEND_REQUEST];
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         mbQ[0] <= 6'h00;
         mbQ[1] <= 6'h00;
      end else begin
         mbQ[0] <= mbD[0];
         mbQ[1] <= mbD[1];
      end
   end

   // Pages 2 to 7 never expose a transmit mailbox for writing.
   assign mailboxWriteEn = (pageQ == 3'h0 || pageQ == 3'h1) &&
                           mailboxEmpty[pageQ[0]];

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------
   always_comb begin
      rdDataD = 8'h00;
      if (regRead) begin
         case (regAddr)
            `CETM_OFF_ERROR_STATUS: rdDataD = {1'b0, lecQ, 1'b0, busOffQ, passiveFlag, warnFlag};
            `CETM_OFF_ERROR_IRQ_EN: rdDataD = irqEnQ;
            `CETM_OFF_TX_ERR_COUNT: rdDataD = tecQ[7:0];
            `CETM_OFF_RX_ERR_COUNT: rdDataD = recQ;
            `CETM_OFF_DIAGNOSIS: rdDataD = {4'h0, canRx, sampleQ, silentQ, loopQ};
            `CETM_OFF_TIMING_PRESCALE: rdDataD = prescaleQ;
            `CETM_OFF_TIMING_SEGMENTS: rdDataD = {1'b0, segmentsQ};
            `CETM_OFF_PAGE_SELECT: rdDataD = {5'h00, pageQ};
            `CETM_OFF_MAILBOX0: rdDataD = {2'b00, mbQ[0]};
            `CETM_OFF_MAILBOX1: rdDataD = {2'b00, mbQ[1]};
            `CETM_OFF_TRANSMIT_STATUS: rdDataD = {2'b00, mbQ[1][`CETM_BIT_TX_SUCCESS],
               mbQ[0][`CETM_BIT_TX_SUCCESS], 2'b00, mbQ[1][`CETM_BIT_REQUEST_COMPLETED], mbQ[0][`CETM_BIT_REQUEST_COMPLETED]};
            `CETM_OFF_MASTER_CONTROL: rdDataD = {7'h00, initReqQ};
            `CETM_OFF_MASTER_STATUS: rdDataD = {5'h00, errIrqFlagQ, 1'b0, initAcknowledge};
            default: rdDataD = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rdDataQ <= 8'h00;
      end else begin
         rdDataQ <= rdDataD;
      end
   end

   assign regRdData = rdDataQ;

endmodule : cetm_core

// ### cetm_core_properties.sv
// Port-level properties of the error, timing and mailbox block.
`timescale 1ns/1ps
module cetm_core_properties (
   input logic ref_clk,
   input logic resetn,
   input logic [3:0] regAddr,
   input logic [7:0] regWrData,
   input logic regWrite,
   input logic regRead,
   input logic [7:0] regRdData,
   input logic canRx,
   input logic busActive,
   input logic [1:0] sendPending,
   input logic [1:0] abortPending,
   input logic [1:0] mailboxEmpty,
   input logic mailboxWriteEn,
   input logic [2:0] pageNumber,
   input logic samplePoint,
   input logic initAcknowledge,
   input logic errorIrq,
   input logic errorIrqFlag
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   a_empty_mirror: assert property (mailboxEmpty == ~sendPending)
      else $error("empty flag disagrees with pending request");
   a_irq_gate: assert property (errorIrq |-> errorIrqFlag)
      else $error("interrupt raised without pending flag");
   a_abort_clear: assert property ($fell(sendPending[0]) |-> ##[0:1] !abortPending[0])
      else $error("abort bit outlives the pending request");
   a_write_gate: assert property (mailboxWriteEn == (pageNumber <= 3'h1
      && mailboxEmpty[pageNumber[0]])) else $error("mailbox write enable wrong");
   a_page_load: assert property (regWrite && regAddr == 4'h7
      |=> pageNumber == $past(regWrData[2:0])) else $error("page number not loaded");
   a_sample_source: assert property ($changed(samplePoint)
      |-> samplePoint == $past(canRx) || samplePoint == $past(canRx, 2))
      else $error("sample value not taken from the receive pin");
   a_send_taken: assert property (regWrite && regAddr == 4'h8 && regWrData[0]
      && mailboxEmpty[0] |=> sendPending[0]) else $error("send request not taken");
   a_init_waits: assert property ($rose(initAcknowledge) |-> !$past(busActive))
      else $error("init entered while a frame was active");
   a_read_idle: assert property (!regRead |=> regRdData == 8'h00)
      else $error("read data not zero outside the read answer cycle");
endmodule : cetm_core_properties

bind cetm_core cetm_core_properties u_cetm_core_properties (.ref_clk(ref_clk),
   .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
   .regRead(regRead), .regRdData(regRdData), .canRx(canRx), .busActive(busActive),
   .sendPending(sendPending), .abortPending(abortPending), .mailboxEmpty(mailboxEmpty),
   .mailboxWriteEn(mailboxWriteEn), .pageNumber(pageNumber), .samplePoint(samplePoint),
   .initAcknowledge(initAcknowledge), .errorIrq(errorIrq), .errorIrqFlag(errorIrqFlag));

// ### cetm_pkg.sv
// Types shared by the error, timing and mailbox block.
package cetm_pkg;
   typedef enum logic [2:0] {
      CETM_LEC_NONE = 3'h0,
      CETM_LEC_STUFF = 3'h1,
      CETM_LEC_FORM = 3'h2,
      CETM_LEC_ACK = 3'h3,
      CETM_LEC_BIT_REC = 3'h4,
      CETM_LEC_BIT_DOM = 3'h5,
      CETM_LEC_CRC = 3'h6,
      CETM_LEC_SOFT = 3'h7
   } cetm_lec_e;

   typedef enum logic [1:0] {
      CETM_RUN = 2'b00,
      CETM_INIT_WAIT = 2'b01,
      CETM_INIT = 2'b11
   } cetm_mode_e;

   typedef enum logic [1:0] {
      CETM_SEG_SYNC = 2'b00,
      CETM_SEG_ONE = 2'b01,
      CETM_SEG_TWO = 2'b11
   } cetm_seg_e;
endpackage : cetm_pkg

// ### cetm_regs.svh
// Register offsets, field positions and reset values of the error, timing and mailbox block.
`ifndef CETM_REGS_SVH
`define CETM_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CETM_OFF_ERROR_STATUS 4'h0
`define CETM_OFF_ERROR_IRQ_EN 4'h1
`define CETM_OFF_TX_ERR_COUNT 4'h2
`define CETM_OFF_RX_ERR_COUNT 4'h3
`define CETM_OFF_DIAGNOSIS 4'h4
`define CETM_OFF_TIMING_PRESCALE 4'h5
`define CETM_OFF_TIMING_SEGMENTS 4'h6
`define CETM_OFF_PAGE_SELECT 4'h7
`define CETM_OFF_MAILBOX0 4'h8
`define CETM_OFF_MAILBOX1 4'h9
`define CETM_OFF_TRANSMIT_STATUS 4'hA
`define CETM_OFF_MASTER_CONTROL 4'hB
`define CETM_OFF_MASTER_STATUS 4'hC

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CETM_RST_SEGMENTS 7'h23
`define CETM_RST_PAGE 3'h0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CETM_BIT_ERROR_IRQ_ENABLE 7
`define CETM_BIT_CODE_UPDATE_IRQ_ENABLE 4
`define CETM_BIT_BUS_OFF_FLAG 2
`define CETM_BIT_ERROR_PASSIVE_FLAG 1
`define CETM_BIT_ERROR_WARNING_FLAG 0
`define CETM_BIT_TX_ERROR_STATUS 5
`define CETM_BIT_ARBITRATION_LOST 4
`define CETM_BIT_TX_SUCCESS 3
`define CETM_BIT_REQUEST_COMPLETED 2
`define CETM_BIT_ABORT_REQUEST 1
`define CETM_BIT_SEND_REQUEST 0

// ----------------------------------------------------------------
// Counter limits
// ----------------------------------------------------------------
`define CETM_WARN_LIMIT 9'd96
`define CETM_PASSIVE_LIMIT 9'd127
`define CETM_BUSOFF_LIMIT 9'd255
`define CETM_REC_HIGH 8'd128
`define CETM_REC_RELOAD 8'd120
`define CETM_REC_BIG_STEP 8'd8
`define CETM_LEC_SOFT 3'h7

`endif

// ### tb_can_error_timing_txmailbox.sv
// Self-checking bench of the error, timing and mailbox block.
`timescale 1ns/1ps
`define CETM_CHK(a, b) begin nCompared++; if ((a) !== (b)) begin nMismatch++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_can_error_timing_txmailbox;
   logic ref_clk, resetn, regWrite, regRead, canRx, canTx, busActive, errDetect;
   logic [3:0] regAddr;
   logic [7:0] regWrData, regRdData, d;
   logic [2:0] errCode, pageNumber;
   logic rxErrEvent, rxErrBig, txErrEvent, txErrBig, rxGood, txGood, attemptOk, protoTx;
   logic [1:0] attemptDone, sendPending, abortPending, mailboxEmpty;
   logic mailboxWriteEn, samplePoint, quantumTick, initAcknowledge, errorIrq, errorIrqFlag;
   logic attemptLost;
   int nMismatch = 0, nCompared = 0, seed = 78, receive_fault_count = 0, transmit_fault_count = 0, k, n;

   cetm_core u_cetm_core (.ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .canRx(canRx), .canTx(canTx), .busActive(busActive), .errDetect(errDetect),
      .errCode(errCode), .rxErrEvent(rxErrEvent), .rxErrBig(rxErrBig),
      .txErrEvent(txErrEvent), .txErrBig(txErrBig), .rxGood(rxGood), .txGood(txGood),
      .attemptDone(attemptDone), .attemptOk(attemptOk), .attemptLost(attemptLost),
      .resyncReq(1'b0), .resyncLonger(1'b0), .resyncPhase(2'h0), .protoTx(protoTx),
      .sendPending(sendPending), .abortPending(abortPending), .mailboxEmpty(mailboxEmpty),
      .mailboxWriteEn(mailboxWriteEn), .pageNumber(pageNumber), .samplePoint(samplePoint),
      .quantumTick(quantumTick), .initAcknowledge(initAcknowledge), .errorIrq(errorIrq),
      .errorIrqFlag(errorIrqFlag));
   cetm_bus_node u_cetm_bus_node (.ref_clk(ref_clk), .resetn(resetn), .canTx(canTx),
      .busActive(busActive), .quantumTick(quantumTick), .canRx(canRx));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // ----------------------------------------------------------------
   // Bus cycles and expectations
   // ----------------------------------------------------------------
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= v;
      @(posedge ref_clk);
      regWrite <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRead <= 1'b0;
      #1 d = regRdData;
   endtask : rd

   // Kind 0 receive error, 1 transmit error, 2 good receive, 3 good transmit, else bus error.
   task automatic evt(input int kind, input logic big, input logic [2:0] code);
      @(posedge ref_clk);
      case (kind)
         0: rxErrEvent <= 1'b1;
         1: txErrEvent <= 1'b1;
         2: rxGood <= 1'b1;
         3: txGood <= 1'b1;
         default: errDetect <= 1'b1;
      endcase
      {rxErrBig, txErrBig, errCode} <= {big, big, code};
      @(posedge ref_clk);
      {rxErrEvent, txErrEvent, rxGood, txGood, errDetect} <= 5'h00;
   endtask : evt

   task automatic attempt(input logic [1:0] m, input logic ok, input logic lost);
      @(posedge ref_clk);
      attemptDone <= m;
      attemptOk <= ok;
      attemptLost <= lost;
      @(posedge ref_clk);
      attemptDone <= 2'h0;
   endtask : attempt

   function automatic logic [7:0] expStat(input logic [2:0] last_error_code, input logic bus_off_flag);
      return {1'b0, last_error_code, 1'b0, bus_off_flag, receive_fault_count > 127 || transmit_fault_count > 127, receive_fault_count > 96 || transmit_fault_count > 96};
   endfunction : expStat

   task automatic close_out();
      $display("compared %0d mismatches %0d", nCompared, nMismatch);
      if (nMismatch == 0 && nCompared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {resetn, regWrite, regRead, busActive, errDetect, rxErrEvent, rxErrBig} = '0;
      {txErrEvent, txErrBig, rxGood, txGood, attemptOk, regAddr, regWrData} = '0;
      {errCode, attemptDone, attemptLost} = '0;
      protoTx = 1'b1;
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      for (k = 0; k < 16; k++) begin
         rd(k[3:0]);
         `CETM_CHK(d, (k == 4) ? 8'h0C : (k == 6) ? 8'h23 : 8'h00)
      end
      for (k = 0; k < 8; k++) begin
         n = (k < 2) ? k : $random(seed);
         wr(4'h7, n[7:0]);
         rd(4'h7);
         `CETM_CHK(d, {5'h00, n[2:0]})
         `CETM_CHK(mailboxWriteEn, n[2:0] <= 3'h1)
      end
      wr(4'h7, 8'h00);
      @(posedge ref_clk) protoTx <= 1'b0;
      wr(4'h4, 8'h03);
      repeat (20) @(posedge ref_clk);
      `CETM_CHK(canTx, 1'b1)
      rd(4'h4);
      `CETM_CHK(d, 8'h0F)
      wr(4'h4, 8'h00);
      repeat (20) @(posedge ref_clk);
      `CETM_CHK(canTx, 1'b0)
      rd(4'h4);
      `CETM_CHK(d, 8'h00)
      @(posedge ref_clk) protoTx <= 1'b1;
      wr(4'h8, 8'h01);
      rd(4'h8);
      `CETM_CHK(d, 8'h01)
      `CETM_CHK(mailboxWriteEn, 1'b0)
      attempt(2'b01, 1'b0, 1'b1);
      rd(4'h8);
      `CETM_CHK(d, 8'h11)
      attempt(2'b01, 1'b0, 1'b0);
      rd(4'h8);
      `CETM_CHK(d, 8'h21)
      attempt(2'b01, 1'b1, 1'b0);
      rd(4'h8);
      `CETM_CHK(d, 8'h0C)
      rd(4'hA);
      `CETM_CHK(d, 8'h11)
      wr(4'h8, 8'h04);
      rd(4'hA);
      `CETM_CHK(d, 8'h00)
      wr(4'h8, 8'h02);
      rd(4'h8);
      `CETM_CHK(d, 8'h00)
      wr(4'h9, 8'h01);
      wr(4'h9, 8'h02);
      rd(4'h9);
      `CETM_CHK(d, 8'h04)
      `CETM_CHK(mailboxEmpty, 2'b11)
      wr(4'h9, 8'h01);
      rd(4'h9);
      `CETM_CHK(d, 8'h01)
      wr(4'h9, 8'h02);
      wr(4'h1, 8'h90);
      evt(4, 1'b0, 3'h3);
      rd(4'h0);
      `CETM_CHK(d, 8'h30)
      `CETM_CHK({errorIrqFlag, errorIrq}, 2'b11)
      wr(4'h1, 8'h10);
      rd(4'h1);
      `CETM_CHK({d, errorIrqFlag, errorIrq}, {8'h10, 2'b10})
      wr(4'hC, 8'h04);
      wr(4'h1, 8'h00);
      for (k = 1; k < 7; k++) begin
         evt(4, 1'b0, k[2:0]);
         rd(4'h0);
         `CETM_CHK(d, {1'b0, k[2:0], 4'h0})
      end
      `CETM_CHK(errorIrqFlag, 1'b0)
      evt(2, 1'b0, 3'h0);
      rd(4'h0);
      `CETM_CHK(d, 8'h00)
      wr(4'h0, 8'h70);
      rd(4'h0);
      `CETM_CHK(d, 8'h70)
      evt(3, 1'b0, 3'h0);
      rd(4'h0);
      `CETM_CHK(d, 8'h00)
      wr(4'h1, 8'h81);
      for (k = 0; k < 40; k++) begin
         n = (receive_fault_count > 200) ? 2 : $unsigned($random(seed)) % 3;
         evt((n == 2) ? 2 : 0, n == 1, 3'h0);
         if (n == 2) receive_fault_count = (receive_fault_count > 128) ? 120 : (receive_fault_count > 0) ? receive_fault_count - 1 : 0;
         else receive_fault_count += (n == 1) ? 8 : 1;
         rd(4'h3);
         `CETM_CHK(d, receive_fault_count[7:0])
         rd(4'h0);
         `CETM_CHK(d, expStat(3'h0, 1'b0))
      end
      while (receive_fault_count <= 128) begin
         evt(0, 1'b1, 3'h0);
         receive_fault_count += 8;
      end
      evt(2, 1'b0, 3'h0);
      receive_fault_count = 120;
      rd(4'h3);
      `CETM_CHK(d, 8'd120)
      `CETM_CHK(errorIrqFlag, 1'b1)
      wr(4'h1, 8'h84);
      wr(4'hC, 8'h04);
      for (k = 0; k < 32; k++) begin
         evt(1, 1'b1, 3'h0);
         transmit_fault_count += 8;
         rd(4'h2);
         `CETM_CHK(d, transmit_fault_count[7:0])
         rd(4'h0);
         `CETM_CHK(d, expStat(3'h0, transmit_fault_count > 255))
         `CETM_CHK(errorIrqFlag, transmit_fault_count > 255)
      end
      wr(4'h5, 8'h45);
      rd(4'h5);
      `CETM_CHK(d, 8'h00)
      @(posedge ref_clk) busActive <= 1'b1;
      wr(4'hB, 8'h01);
      repeat (5) @(posedge ref_clk);
      `CETM_CHK(initAcknowledge, 1'b0)
      @(posedge ref_clk) busActive <= 1'b0;
      for (n = 0; n < 50 && initAcknowledge !== 1'b1; n++) @(posedge ref_clk);
      if (n == 50) begin
         nMismatch++;
         close_out();
      end
      wr(4'h5, 8'h45);
      rd(4'h5);
      `CETM_CHK(d, 8'h45)
      wr(4'h6, 8'hFF);
      rd(4'h6);
      `CETM_CHK(d, 8'h7F)
      wr(4'hB, 8'h00);
      k = 0;
      for (n = 0; n < 36; n++) begin
         @(negedge ref_clk);
         if (quantumTick === 1'b1) k++;
      end
      `CETM_CHK(k, 6)
      close_out();
   end
endmodule : tb_can_error_timing_txmailbox
